// ===== mtg_regs.vh
// Operation
// [RQ1] Generators one to three give square or trapezoid per wave shape bit.
// [RQ2] Additive generator always gives a trapezoid.
// [RQ3] Stepping cycles generators 1-2 (count 0) or 1-2-3 (count 1).
// [RQ4] Without stepping, continuous tone from generator 1 (count 0) or 2.
// [RQ5] Dual add sums additive generator, gain indexed by active generator.
// [RQ6] Software uses dual add and three steps only outside keypad mode.
// [RQ7] Step durations 10 ms to 8 s from two coefficient bytes.
// [RQ8] Generator and additive gains 0 to -48 dB, one byte each.
// [RQ9] Gain 0 dB equals full PCM level.
// [RQ10] Tone off, continuous, or pulsed per tone-on and pulse bits.
// [RQ11] Pulse on and off intervals 20 ms to 16 min, two bytes each.
// [RQ12] Auto halt stops only after the running sequence completes.
// [RQ13] Direct speaker route feeds tone to speaker, bypassing receive.
// [RQ14] Direct route forces full-amplitude square, ignoring wave shape.
// [RQ15] Filter enable inserts equalizer then saturation amplifier.
// [RQ16] Equalizer is band-pass with center, bandwidth, stop-band terms.
// [RQ17] Saturation amp gain +12 to -12 dB then clip at full level.
// [RQ18] Separate tx/rx tone levels, muteable, added only when switched; keypad mode adds the tx tone without the tx switch.
// [RQ19] Keypad mode sums generator three and additive trapezoids into tx.
// [RQ20] Tx tone switch adds the tone to the outgoing tx signal.
// [RQ21] Pulsing starts with on; stepping restarts at step one on start.
`ifndef MTG_REGS_VH
`define MTG_REGS_VH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define MTG_ADDR_CFG     6'h00
`define MTG_ADDR_SW      6'h01
`define MTG_ADDR_STAT    6'h02
`define MTG_ADDR_COEF    6'h20
`define MTG_CFG_RST      8'h00
`define MTG_SW_RST       8'h00
// ----------------------------------------------------------------
// Configuration bits
// ----------------------------------------------------------------
`define MTG_CFG_SHAPE    0
`define MTG_CFG_STEP     1
`define MTG_CFG_COUNT    2
`define MTG_CFG_ON       3
`define MTG_CFG_PULSE    4
`define MTG_CFG_HALT     5
// ----------------------------------------------------------------
// Switch bits
// ----------------------------------------------------------------
`define MTG_SW_DUAL      0
`define MTG_SW_KEYPAD    1
`define MTG_SW_SPEAKER   2
`define MTG_SW_FILTER    3
`define MTG_SW_TX        4
`define MTG_SW_RX        5
// ----------------------------------------------------------------
// Coefficient byte indices (high byte first)
// ----------------------------------------------------------------
`define MTG_C_FREQ       0
`define MTG_C_GLVL       8
`define MTG_C_ALVL       11
`define MTG_C_DUR        14
`define MTG_C_TON        20
`define MTG_C_OFF_INTERVAL       22
`define MTG_C_CENTER     24
`define MTG_C_BAND       25
`define MTG_C_STOP       26
`define MTG_C_SAT        27
`define MTG_C_TXLVL      28
`define MTG_C_RXLVL      29
`define MTG_COEF_DEPTH   32
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MTG_CLK_HZ       200000000
`define MTG_SAMPLE_HZ    8000
`define MTG_SAMPLE_CYCLES (`MTG_CLK_HZ / `MTG_SAMPLE_HZ)
`define MTG_UNIT_MS      10
`define MTG_UNIT_SAMPLES (`MTG_UNIT_MS * `MTG_SAMPLE_HZ / 1000)
`define MTG_FULL         16'h7FFF
`define MTG_MUTE         8'hFF
`endif

// ===== mtg_gain.v
`include "mtg_regs.vh"
module mtg_gain (
  // Sample and level
  input  wire signed [15:0] sampleIn,
  input  wire        [7:0]  level,
  // Scaled sample
  output wire signed [15:0] sampleOut
);
  // ----------------------------------------------------------------
  // Coarse 6 dB shift, fine linear trim; 0 means full level
  // ----------------------------------------------------------------
  wire signed [15:0] shifted = sampleIn >>> level[7:4];
  wire signed [5:0]  trim    = 6'sd16 - $signed({2'b00, level[3:0]});
  wire signed [21:0] prod    = shifted * trim;
  assign sampleOut = (level == `MTG_MUTE) ? 16'sh0000 : prod[19:4]; // [RQ8] [RQ9] [RQ18]
endmodule

// ===== mtg_wavegen.v
`include "mtg_regs.vh"
module mtg_wavegen (
  // Clock and reset
  input  wire               ref_clk,
  input  wire               resetn,
  // Control
  input  wire               sampleTick,
  input  wire               restart,
  input  wire               squareSel,
  input  wire        [15:0] freqWord,
  // Output
  output wire signed [15:0] wave
);
  reg  [15:0] phaseQ;
  wire [14:0] triWave = phaseQ[15] ? ~phaseQ[14:0] : phaseQ[14:0];
  wire signed [17:0] centered = $signed({3'b000, triWave}) - 18'sd16384;
  // Triangle times four, clipped: flat tops make the trapezoid
  wire signed [19:0] steep = {centered, 2'b00};
  wire signed [15:0] trap  = (steep > 20'sd32767) ? 16'sh7FFF :
                             (steep < -20'sd32767) ? -16'sh7FFF :
                             steep[15:0];
  wire signed [15:0] sq    = phaseQ[15] ? -16'sh7FFF : 16'sh7FFF;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phaseQ <= 16'h0000;
    end else if (restart) begin
      phaseQ <= 16'h0000;
    end else if (sampleTick) begin
      phaseQ <= phaseQ + freqWord;
    end
  end

  assign wave = squareSel ? sq : trap; // [RQ1] [RQ2]
endmodule

// ===== mtg_top.v
`include "mtg_regs.vh"
module mtg_top #(
  parameter SAMPLE_CYCLES = `MTG_SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire               ref_clk,
  input  wire               resetn,
  // Register port
  input  wire        [5:0]  regAddr,
  input  wire        [7:0]  regWdata,
  input  wire               regWr,
  input  wire               regRd,
  output reg         [7:0]  regRdata,
  // Voice paths at the sample rate
  input  wire signed [15:0] txIn,
  input  wire signed [15:0] rxIn,
  output reg  signed [15:0] txOut,
  output reg  signed [15:0] rxOut,
  output reg  signed [15:0] spkOut,
  output reg                sampleStrobe
);
  // ----------------------------------------------------------------
  // Registers and coefficient memory
  // ----------------------------------------------------------------
  reg  [7:0] toneConfigReg;
  reg  [7:0] toneSwitchReg;
  reg  [7:0] coefMem [0:`MTG_COEF_DEPTH-1];
  integer    k;

  wire shapeSel   = toneConfigReg[`MTG_CFG_SHAPE];
  wire stepEn     = toneConfigReg[`MTG_CFG_STEP];
  wire countSel   = toneConfigReg[`MTG_CFG_COUNT];
  wire toneOnBit  = toneConfigReg[`MTG_CFG_ON];
  wire pulseSel   = toneConfigReg[`MTG_CFG_PULSE];
  wire haltSel    = toneConfigReg[`MTG_CFG_HALT];
  wire dualAdd    = toneSwitchReg[`MTG_SW_DUAL];
  wire keypadMode = toneSwitchReg[`MTG_SW_KEYPAD];
  wire speakerRt  = toneSwitchReg[`MTG_SW_SPEAKER];
  wire filterEn   = toneSwitchReg[`MTG_SW_FILTER];
  wire txSwitch   = toneSwitchReg[`MTG_SW_TX];
  wire rxSwitch   = toneSwitchReg[`MTG_SW_RX];

  reg        runQ;
  reg        pulseOnQ;
  reg  [1:0] stepQ;
  wire       coefHit = (regAddr[5] == 1'b1);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      toneConfigReg <= `MTG_CFG_RST;
      toneSwitchReg <= `MTG_SW_RST;
      for (k = 0; k < `MTG_COEF_DEPTH; k = k + 1) begin
        coefMem[k] <= 8'h00;
      end
    end else if (regWr) begin
      if (regAddr == `MTG_ADDR_CFG) begin
        toneConfigReg <= regWdata;
      end
      if (regAddr == `MTG_ADDR_SW) begin
        toneSwitchReg <= regWdata;
      end
      if (coefHit) begin
        coefMem[regAddr[4:0]] <= regWdata;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (regAddr == `MTG_ADDR_CFG) begin
        regRdata <= toneConfigReg;
      end else if (regAddr == `MTG_ADDR_SW) begin
        regRdata <= toneSwitchReg;
      end else if (regAddr == `MTG_ADDR_STAT) begin
        regRdata <= {4'h0, stepQ, pulseOnQ, runQ};
      end else if (coefHit) begin
        regRdata <= coefMem[regAddr[4:0]];
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Sample and 10 ms unit ticks
  // ----------------------------------------------------------------
  reg  [15:0] smpCntQ;
  reg  [7:0]  unitCntQ;
  wire        smpTick  = (smpCntQ == SAMPLE_CYCLES - 1);
  wire        startEvt = toneOnBit & ~runQ;
  wire        unitTick = smpTick & (unitCntQ == `MTG_UNIT_SAMPLES - 1);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      smpCntQ  <= 16'h0000;
      unitCntQ <= 8'h00;
    end else begin
      smpCntQ <= smpTick ? 16'h0000 : smpCntQ + 16'h0001;
      if (startEvt) begin
        unitCntQ <= 8'h00;
      end else if (smpTick) begin
        unitCntQ <= unitTick ? 8'h00 : unitCntQ + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and control generator
  // ----------------------------------------------------------------
  reg  [15:0] durCntQ;
  reg  [16:0] pulseCntQ;
  localparam integer DUR_BASE = `MTG_C_DUR;
  wire [4:0]  durIdx   = DUR_BASE[4:0] + {2'b00, stepQ, 1'b0};
  wire [15:0] stepDur  = {coefMem[durIdx], coefMem[durIdx + 5'd1]};
  wire        lastStep = countSel ? (stepQ == 2'd2) : (stepQ == 2'd1);
  wire        stepDone = ({1'b0, durCntQ} + 17'h0_0001) >= {1'b0, stepDur};
  wire        seqEnd   = stepEn & unitTick & stepDone & lastStep;
  wire [15:0] ivalRaw  = pulseOnQ ?
                         {coefMem[`MTG_C_TON], coefMem[`MTG_C_TON+1]} :
                         {coefMem[`MTG_C_OFF_INTERVAL], coefMem[`MTG_C_OFF_INTERVAL+1]};
  wire [16:0] ivalLen  = {ivalRaw, 1'b0}; // 20 ms units from 10 ms ticks
  wire        ivalDone = (pulseCntQ + 17'h0_0001) >= ivalLen;
  wire        stopNow  = ~toneOnBit & (~(haltSel & stepEn) | seqEnd);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      runQ      <= 1'b0;
      stepQ     <= 2'd0;
      durCntQ   <= 16'h0000;
      pulseOnQ  <= 1'b1;
      pulseCntQ <= 17'h0_0000;
    end else if (startEvt) begin
      runQ      <= 1'b1; // [RQ10]
      stepQ     <= 2'd0; // [RQ21]
      durCntQ   <= 16'h0000;
      pulseOnQ  <= 1'b1; // [RQ21]
      pulseCntQ <= 17'h0_0000;
    end else if (runQ) begin
      if (stopNow) begin
        runQ <= 1'b0; // [RQ12]
      end
      if (unitTick & stepEn) begin
        if (stepDone) begin
          durCntQ <= 16'h0000; // [RQ7]
          stepQ   <= lastStep ? 2'd0 : stepQ + 2'd1; // [RQ3]
        end else begin
          durCntQ <= durCntQ + 16'h0001;
        end
      end
      if (unitTick & pulseSel) begin
        if (ivalDone) begin
          pulseCntQ <= 17'h0_0000; // [RQ11]
          pulseOnQ  <= ~pulseOnQ; // [RQ10]
        end else begin
          pulseCntQ <= pulseCntQ + 17'h0_0001;
        end
      end else if (!pulseSel) begin
        pulseOnQ  <= 1'b1;
        pulseCntQ <= 17'h0_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Signal generators
  // ----------------------------------------------------------------
  wire [1:0] activeGen = keypadMode ? 2'd2 :
                         stepEn ? stepQ : {1'b0, countSel}; // [RQ3] [RQ4]
  wire signed [15:0] rawWave [0:3];
  wire signed [15:0] lvlWave [0:3];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_tone
      localparam integer FI = `MTG_C_FREQ + 2 * g;
      localparam integer GI = `MTG_C_GLVL + g;
      localparam integer AI = `MTG_C_ALVL;
      wire [4:0] fIdx  = FI[4:0];
      wire [4:0] lIdx  = (g == 3) ? (AI[4:0] + {3'b000, activeGen}) :
                                    GI[4:0];
      // Direct speaker route forces square and keypad needs trapezoid
      wire       sqSel = (g != 3) &
                         ((shapeSel & ~keypadMode) | speakerRt);
      mtg_wavegen u_gen (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .sampleTick (smpTick),
        .restart    (startEvt),
        .squareSel  (sqSel), // [RQ1] [RQ2] [RQ14]
        .freqWord   ({coefMem[fIdx], coefMem[fIdx + 5'd1]}),
        .wave       (rawWave[g])
      );
      mtg_gain u_lvl (
        .sampleIn  (rawWave[g]),
        .level     (coefMem[lIdx]), // [RQ5] [RQ8]
        .sampleOut (lvlWave[g])
      );
    end
  endgenerate

  wire               addOn   = dualAdd | keypadMode; // [RQ5] [RQ19]
  wire signed [16:0] toneSum = $signed({lvlWave[activeGen][15],
                                        lvlWave[activeGen]}) +
                               (addOn ? $signed({lvlWave[3][15], lvlWave[3]})
                                      : 17'sh0_0000);

  function signed [15:0] clip;
    input signed [19:0] v;
    begin
      if (v > 20'sd32767) begin
        clip = 16'sh7FFF;
      end else if (v < -20'sd32767) begin
        clip = -16'sh7FFF;
      end else begin
        clip = v[15:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Tone filter: band-pass then saturation amplifier
  // ----------------------------------------------------------------
  reg  signed [15:0] x1Q, x2Q, y1Q, y2Q;
  wire signed [15:0] eqIn  = clip({{3{toneSum[16]}}, toneSum});
  wire signed [7:0]  aCtr  = coefMem[`MTG_C_CENTER];
  wire signed [7:0]  aBand = coefMem[`MTG_C_BAND];
  wire [7:0]         kStop = coefMem[`MTG_C_STOP];
  wire signed [23:0] fbA   = aCtr * y1Q;
  wire signed [23:0] fbB   = aBand * y2Q;
  wire signed [19:0] diff  = $signed({{4{eqIn[15]}}, eqIn}) -
                             $signed({{4{x2Q[15]}}, x2Q});
  // Stop-band leak is the input dropped by 6 dB per step; 9 steps = none
  wire [3:0]         kSh   = (kStop[7:3] > 5'd8) ? 4'd9 : kStop[6:3];
  wire signed [15:0] leak  = (kSh == 4'd9) ? 16'sh0000 : (eqIn >>> kSh);
  // Feedback terms sign-extended so the sum stays signed
  wire signed [19:0] eqSum = (diff >>> 1) +
                             $signed({{2{fbA[23]}}, fbA[23:6]}) +
                             $signed({{3{fbB[23]}}, fbB[23:7]});
  wire signed [15:0] eqOut = clip(eqSum); // [RQ16]
  wire signed [7:0]  satG  = coefMem[`MTG_C_SAT];
  // Gain in 6 dB steps, held to +/-12 dB, then clipped at full level
  wire [1:0]         satM  = satG[7] ? ((satG < -8'sd2) ? 2'd2 : -satG[1:0])
                                     : ((satG > 8'sd2) ? 2'd2 : satG[1:0]);
  wire signed [19:0] satX  = $signed({{4{eqOut[15]}}, eqOut}) +
                             $signed({{4{leak[15]}}, leak});
  wire signed [15:0] satOut = satG[7] ? clip(satX >>> satM)
                                      : clip(satX <<< satM); // [RQ17]

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      x1Q <= 16'sh0000;
      x2Q <= 16'sh0000;
      y1Q <= 16'sh0000;
      y2Q <= 16'sh0000;
    end else if (smpTick) begin
      x1Q <= eqIn;
      x2Q <= x1Q;
      y1Q <= eqOut;
      y2Q <= y1Q;
    end
  end

  wire audible = runQ & pulseOnQ; // [RQ10]
  wire signed [15:0] toneSig = ~audible ? 16'sh0000 :
                               filterEn ? satOut : eqIn; // [RQ15]

  // ----------------------------------------------------------------
  // Level stages and path mixing
  // ----------------------------------------------------------------
  wire signed [15:0] txTone;
  wire signed [15:0] rxTone;

  mtg_gain u_txlvl (
    .sampleIn  (toneSig),
    .level     (coefMem[`MTG_C_TXLVL]), // [RQ18]
    .sampleOut (txTone)
  );

  mtg_gain u_rxlvl (
    .sampleIn  (toneSig),
    .level     (coefMem[`MTG_C_RXLVL]), // [RQ18]
    .sampleOut (rxTone)
  );

  wire txAdd = txSwitch | keypadMode; // [RQ19] [RQ20]
  wire rxAdd = rxSwitch & ~speakerRt; // [RQ13] [RQ18]
  wire signed [19:0] txMix = $signed({{4{txIn[15]}}, txIn}) +
                             (txAdd ? $signed({{4{txTone[15]}}, txTone})
                                    : 20'sh0_0000);
  wire signed [19:0] rxMix = $signed({{4{rxIn[15]}}, rxIn}) +
                             (rxAdd ? $signed({{4{rxTone[15]}}, rxTone})
                                    : 20'sh0_0000);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txOut        <= 16'sh0000;
      rxOut        <= 16'sh0000;
      spkOut       <= 16'sh0000;
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= smpTick;
      if (smpTick) begin
        txOut  <= clip(txMix);
        rxOut  <= clip(rxMix);
        // Raw generator square drives the speaker at full swing
        spkOut <= (speakerRt & audible) ? rawWave[activeGen]
                                        : 16'sh0000; // [RQ13] [RQ14]
      end
    end
  end
endmodule

// ===== mtg_top_asserts.sv
`include "mtg_regs.vh"
module mtg_top_asserts #(
  parameter SAMPLE_CYCLES = `MTG_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire               ref_clk,
  input wire               resetn,
  // Register port
  input wire        [5:0]  regAddr,
  input wire        [7:0]  regWdata,
  input wire               regWr,
  input wire               regRd,
  input wire        [7:0]  regRdata,
  // Voice paths
  input wire signed [15:0] txIn,
  input wire signed [15:0] rxIn,
  input wire signed [15:0] txOut,
  input wire signed [15:0] rxOut,
  input wire signed [15:0] spkOut,
  input wire               sampleStrobe
);
  // --------------------------------
  // Shadow of software state
  // --------------------------------
  logic [7:0]  cfg_q;
  logic [7:0]  sw_q;
  logic [7:0]  coef_q [0:31];
  logic [1:0]  settle_q;
  logic [31:0] gap_q;
  logic        seen_q;
  logic [7:0]  rdExp;
  logic        calm;
  // Three samples after a config or switch write, so no sample in flight is judged
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q    <= 8'h00;
      sw_q     <= 8'h00;
      settle_q <= 2'h0;
      gap_q    <= 32'h0000_0000;
      seen_q   <= 1'h0;
      for (int i = 0; i < 32; i++) coef_q[i] <= 8'h00;
    end else begin
      if (regWr && regAddr == `MTG_ADDR_CFG) cfg_q <= regWdata;
      if (regWr && regAddr == `MTG_ADDR_SW) sw_q <= regWdata;
      if (regWr && regAddr[5]) coef_q[regAddr[4:0]] <= regWdata;
      if (regWr && regAddr[5:1] == 5'h00) settle_q <= 2'h0;
      else if (sampleStrobe && settle_q != 2'h3) settle_q <= settle_q + 2'h1;
      gap_q  <= sampleStrobe ? 32'h0000_0000 : gap_q + 32'h0000_0001;
      seen_q <= seen_q | sampleStrobe;
    end
  end
  always_comb begin
    rdExp = 8'h00;
    if (regAddr == `MTG_ADDR_CFG) rdExp = cfg_q;
    if (regAddr == `MTG_ADDR_SW) rdExp = sw_q;
    if (regAddr[5]) rdExp = coef_q[regAddr[4:0]];
  end
  assign calm = (settle_q == 2'h3);
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_rd_map;
    regRd && regAddr != `MTG_ADDR_STAT |=> regRdata == $past(rdExp);
  endproperty
  a_rd_map: assert property (p_rd_map)
    else $error("read data differs from written value");
  property p_rd_idle;
    !$past(regRd) |-> regRdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read cycle");
  property p_strobe_one;
    sampleStrobe |=> !sampleStrobe;
  endproperty
  a_strobe_one: assert property (p_strobe_one)
    else $error("sample strobe longer than one cycle");
  property p_strobe_gap;
    sampleStrobe && seen_q |-> gap_q == SAMPLE_CYCLES - 1;
  endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("sample strobe spacing wrong");
  property p_out_hold;
    !sampleStrobe |-> $stable(txOut) && $stable(rxOut) && $stable(spkOut);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("voice output changed between samples");
  property p_tx_pass;
    sampleStrobe && calm && !sw_q[`MTG_SW_TX] && !sw_q[`MTG_SW_KEYPAD]
      |-> txOut == $past(txIn);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("tone on tx path while switched off");
  property p_rx_pass;
    sampleStrobe && calm && (!sw_q[`MTG_SW_RX] || sw_q[`MTG_SW_SPEAKER])
      |-> rxOut == $past(rxIn);
  endproperty
  a_rx_pass: assert property (p_rx_pass)
    else $error("tone on rx path while switched off or routed away");
  property p_spk_set;
    sampleStrobe |-> spkOut inside {16'h0000, 16'h7fff, 16'h8001};
  endproperty
  a_spk_set: assert property (p_spk_set)
    else $error("speaker output not a full square level");
  property p_spk_off;
    sampleStrobe && calm && !sw_q[`MTG_SW_SPEAKER] |-> spkOut == 16'h0000;
  endproperty
  a_spk_off: assert property (p_spk_off)
    else $error("speaker output active without direct route");
  c_rx_tone: cover property (sampleStrobe && rxOut != $past(rxIn));
  c_spk_hi: cover property (sampleStrobe && spkOut == 16'h7fff);
  c_halt: cover property (cfg_q[`MTG_CFG_HALT] && !cfg_q[`MTG_CFG_ON]);
endmodule

bind mtg_top mtg_top_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .txIn(txIn), .rxIn(rxIn), .txOut(txOut), .rxOut(rxOut),
  .spkOut(spkOut), .sampleStrobe(sampleStrobe)
);

// ===== mtg_voice_model.sv
module mtg_voice_model (
  // Clock and reset
  input  wire                ref_clk,
  input  wire                resetn,
  // Codec voice paths
  input  wire                sampleStrobe,
  input  wire signed  [15:0] txOut,
  input  wire signed  [15:0] rxOut,
  output logic signed [15:0] txIn,
  output logic signed [15:0] rxIn,
  // Tone part seen on each path
  output logic signed [15:0] txTone,
  output logic signed [15:0] rxTone
);
  // Voice flips sign every sample, so a stale sample never looks right
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txIn   <= 16'h0100;
      rxIn   <= 16'hff00;
      txTone <= 16'h0000;
      rxTone <= 16'h0000;
    end else if (sampleStrobe) begin
      txTone <= txOut - txIn;
      rxTone <= rxOut - rxIn;
      txIn   <= -txIn;
      rxIn   <= -rxIn;
    end
  end
endmodule

// ===== multitone_generator_tb_top.sv
`include "mtg_regs.vh"
module multitone_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short sample period keeps the 10 ms unit at 80 samples, 1600 cycles
  localparam int SC = 20;
  logic              ref_clk;
  logic              resetn;
  logic       [5:0]  regAddr;
  logic       [7:0]  regWdata;
  logic              regWr;
  logic              regRd;
  wire        [7:0]  regRdata;
  wire signed [15:0] txIn, rxIn, txOut, rxOut, spkOut, txTone, rxTone;
  wire               sampleStrobe;
  logic       [7:0]  v;
  int                miscompares, samplesChecked, nzRx, nzTx, hi, lo;

  mtg_top #(.SAMPLE_CYCLES(SC)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .txIn(txIn), .rxIn(rxIn), .txOut(txOut),
    .rxOut(rxOut), .spkOut(spkOut), .sampleStrobe(sampleStrobe));
  mtg_voice_model i_voice (
    .ref_clk(ref_clk), .resetn(resetn), .sampleStrobe(sampleStrobe),
    .txOut(txOut), .rxOut(rxOut), .txIn(txIn), .rxIn(rxIn),
    .txTone(txTone), .rxTone(rxTone));

  always #2.5 ref_clk = ~ref_clk;
  // --------------------------------
  // Bus, sample and compare tasks
  // --------------------------------
  task automatic cmp8(input string what, input logic [7:0] e, got);
    samplesChecked++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic cmp1(input string what, input logic e, got);
    cmp8(what, {7'h00, e}, {7'h00, got});
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    #1;
    d = regRdata;
  endtask
  task automatic nextSample();
    int n;
    for (n = 0; n < 4 * SC; n++) begin
      @(posedge ref_clk);
      if (sampleStrobe === 1'h1) break;
    end
    if (n == 4 * SC) begin
      miscompares++;
      conclude();
    end
    #1;
  endtask
  task automatic watch(input int n);
    nzRx = 0;
    nzTx = 0;
    hi = 0;
    lo = 0;
    repeat (n) begin
      nextSample();
      if (rxTone !== 16'h0000) nzRx++;
      if (txTone !== 16'h0000) nzTx++;
      if (spkOut === 16'h7fff) hi++;
      if (spkOut === 16'h8001) lo++;
    end
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_regs();
    rd(`MTG_ADDR_CFG, v);
    cmp8("cfg reset", `MTG_CFG_RST, v);
    rd(`MTG_ADDR_SW, v);
    cmp8("sw reset", `MTG_SW_RST, v);
    wr(`MTG_ADDR_CFG, 8'h1f);
    rd(`MTG_ADDR_CFG, v);
    cmp8("cfg", 8'h1f, v);
    wr(`MTG_ADDR_CFG, 8'h00);
    wr(6'h10, 8'ha5);
    rd(6'h10, v);
    cmp8("unmapped", 8'h00, v);
    wr(`MTG_ADDR_STAT, 8'h0f);
    rd(`MTG_ADDR_STAT, v);
    // Pulse phase rests at on, so the next start opens with on
    cmp8("status idle", 8'h02, v);
    for (int i = 0; i < 32; i++) wr(`MTG_ADDR_COEF + i, 8'(i * 37 + 1));
    for (int i = 0; i < 32; i++) begin
      rd(`MTG_ADDR_COEF + i, v);
      cmp8("coef", 8'(i * 37 + 1), v);
      wr(`MTG_ADDR_COEF + i, 8'h00);
    end
    wr(`MTG_ADDR_COEF + `MTG_C_FREQ, 8'h20);
    wr(`MTG_ADDR_COEF + `MTG_C_FREQ + 2, 8'h10);
    for (int i = 15; i < 24; i += 2) wr(`MTG_ADDR_COEF + i, 8'h01);
    $display("test_regs done");
  endtask
  task automatic test_levels();
    wr(`MTG_ADDR_SW, 8'h31);
    wr(`MTG_ADDR_CFG, 8'h08);
    watch(20);
    cmp1("rx tone", 1'h1, nzRx > 0);
    cmp1("tx tone", 1'h1, nzTx > 0);
    wr(`MTG_ADDR_COEF + `MTG_C_RXLVL, `MTG_MUTE);
    watch(4);
    watch(20);
    cmp1("rx muted", 1'h1, nzRx == 0);
    cmp1("tx kept", 1'h1, nzTx > 0);
    wr(`MTG_ADDR_COEF + `MTG_C_RXLVL, 8'h00);
    wr(`MTG_ADDR_CFG, 8'h00);
    watch(4);
    watch(20);
    cmp1("tone off", 1'h1, nzRx + nzTx == 0);
    $display("test_levels done");
  endtask
  task automatic test_speaker();
    wr(`MTG_ADDR_SW, 8'h24);
    wr(`MTG_ADDR_CFG, 8'h09);
    watch(4);
    watch(16);
    cmp1("square both", 1'h1, hi > 0 && lo > 0);
    cmp1("square full", 1'h1, hi + lo == 16);
    cmp1("rx bypass", 1'h1, nzRx == 0);
    wr(`MTG_ADDR_CFG, 8'h00);
    $display("test_speaker done");
  endtask
  task automatic test_pulse();
    wr(`MTG_ADDR_SW, 8'h20);
    wr(`MTG_ADDR_CFG, 8'h18);
    watch(150);
    cmp1("on first", 1'h1, nzRx > 0);
    watch(20);
    watch(130);
    cmp1("off gap", 1'h1, nzRx == 0);
    watch(40);
    watch(100);
    cmp1("on again", 1'h1, nzRx > 0);
    wr(`MTG_ADDR_CFG, 8'h00);
    $display("test_pulse done");
  endtask
  task automatic test_halt();
    // Keypad mode stays off for stepping and three-tone runs
    wr(`MTG_ADDR_SW, 8'h20);
    wr(`MTG_ADDR_CFG, 8'h2a);
    watch(40);
    rd(`MTG_ADDR_STAT, v);
    cmp8("step one", 8'h00, v & 8'h0c);
    wr(`MTG_ADDR_CFG, 8'h22);
    watch(60);
    rd(`MTG_ADDR_STAT, v);
    cmp8("halt wait", 8'h05, v & 8'h0d);
    watch(100);
    rd(`MTG_ADDR_STAT, v);
    cmp8("halted", 8'h00, v & 8'h01);
    wr(`MTG_ADDR_CFG, 8'h0e);
    watch(200);
    rd(`MTG_ADDR_STAT, v);
    cmp8("step three", 8'h09, v & 8'h0d);
    wr(`MTG_ADDR_CFG, 8'h00);
    $display("test_halt done");
  endtask
  task automatic test_keypad();
    wr(`MTG_ADDR_SW, 8'h0a);
    wr(`MTG_ADDR_CFG, 8'h08);
    watch(20);
    cmp1("keypad tx", 1'h1, nzTx > 0);
    cmp1("keypad rx", 1'h1, nzRx == 0);
    wr(`MTG_ADDR_CFG, 8'h00);
    $display("test_keypad done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'h0;
    resetn = 1'h0;
    regAddr = 6'h00;
    regWdata = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    miscompares = 0;
    samplesChecked = 0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    test_regs();
    test_levels();
    test_speaker();
    test_pulse();
    test_halt();
    test_keypad();
    conclude();
  end
endmodule
